/* File: hdl/pos_sensor_map.vh */
`ifndef POS_SENSOR_MAP_VH
`define POS_SENSOR_MAP_VH

// Attribute identifiers of the position sensor object
`define ATTR_OBJECT_REVISION 8'h01
`define ATTR_ABSOLUTE_POSITION 8'h03
`define ATTR_SENSOR_TYPE 8'h0b
`define ATTR_COUNT_DIRECTION_SELECT 8'h0c
`define ATTR_SCALING_ENABLE 8'h0e
`define ATTR_STEPS_PER_TURN 8'h10
`define ATTR_TOTAL_RANGE 8'h11
`define ATTR_OPERATING_STATUS 8'h29
`define ATTR_PHYSICAL_STEPS_PER_TURN 8'h2a
`define ATTR_PHYSICAL_TURN_COUNT 8'h2b
`define ATTR_WARNING_REPORT 8'h2f
`define ATTR_WRONG_PARAM_LIST 8'h67

// Service codes
`define SVC_GET_ALL 8'h01
`define SVC_RESET 8'h05
`define SVC_GET_SINGLE 8'h0e
`define SVC_SET_SINGLE 8'h10
`define SVC_RESTORE 8'h15
`define SVC_SAVE 8'h16

// Reset types
`define RESET_POWER_CYCLE 8'h00
`define RESET_FACTORY 8'h01

// Answer status codes
`define ST_OK 8'h00
`define ST_NOT_SUPPORTED 8'h08
`define ST_INVALID_VALUE 8'h09
`define ST_NOT_SETTABLE 8'h0e
`define ST_BAD_ATTR 8'h14

// Reset values and fixed figures
`define OBJECT_REVISION_VAL 16'h0002
`define SENSOR_SINGLE_TURN 16'h0001
`define SENSOR_MULTI_TURN 16'h0002
`define COUNT_DIRECTION_RESET 1'b0
`define SCALING_ENABLE_RESET 1'b1

// Operating status and wrong-parameter bit positions
`define OPST_DIR_BIT 0
`define OPST_SCALE_BIT 1
`define WP_SPT_BIT 0
`define WP_RANGE_BIT 1
`define WP_RANGE_LT_SPT_BIT 2
`define WP_TURNS_BIT 3

// Network address for switch values 1..254
`define NET_PREFIX 24'hc0a801
`define NET_SW_MAX 8'hfe

`endif

/* File: hdl/position_sensor_object_scaling.v */
`include "pos_sensor_map.vh"
`default_nettype none

module position_sensor_object_scaling #(
  parameter SPT_LOG2 = 16,
  parameter TURNS_LOG2 = 14
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire svc_valid_i,
  input wire svc_class_i,
  input wire [7:0] svc_code_i,
  input wire [7:0] svc_attr_i,
  input wire [31:0] svc_data_i,
  input wire [31:0] raw_pos_i,
  input wire nv_dir_i,
  input wire nv_scale_i,
  input wire [31:0] nv_spt_i,
  input wire [31:0] nv_range_i,
  input wire [7:0] addr_sw_i,
  input wire [31:0] stored_ip_i,
  output reg svc_ready_o,
  output reg rsp_valid_o,
  output reg rsp_last_o,
  output reg [7:0] rsp_status_o,
  output reg [7:0] rsp_attr_o,
  output reg [31:0] rsp_data_o,
  output reg [31:0] position_o,
  output reg [7:0] op_status_o,
  output reg warning_report_o,
  output reg [7:0] wrong_param_o,
  output reg warn_led_o,
  output reg nv_wr_o,
  output reg nv_dir_o,
  output reg nv_scale_o,
  output reg [31:0] nv_spt_o,
  output reg [31:0] nv_range_o,
  output reg soft_reset_o,
  output reg net_default_o,
  output reg [31:0] net_addr_o
);

  localparam [31:0] PHYS_SPT = 32'h1 << SPT_LOG2;
  localparam [31:0] PHYS_TURNS = 32'h1 << TURNS_LOG2;
  localparam [63:0] PHYS_TOTAL = 64'h1 << (SPT_LOG2 + TURNS_LOG2);
  localparam [31:0] PHYS_TOTAL_32 = PHYS_TOTAL[31:0];

  localparam [2:0] S_LOAD = 3'h0;
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_ALL = 3'h2;
  localparam [2:0] S_SAVE = 3'h3;
  localparam [2:0] S_PWR = 3'h4;

  reg [2:0] state_q;
  reg dir_q;
  reg scale_q;
  reg [31:0] spt_q;
  reg [31:0] range_q;
  reg [2:0] all_idx_q;
  reg [7:0] sw_meta_q;
  reg [7:0] sw_q;
  reg dir_fall_q;
  reg [31:0] pos_d;
  reg [31:0] oriented;
  reg [63:0] product;
  reg [63:0] scaled;
  reg [7:0] all_attr;
  reg [63:0] spt_turns;

  wire [15:0] sensor_type = (TURNS_LOG2 == 0) ? `SENSOR_SINGLE_TURN :
    `SENSOR_MULTI_TURN;

  // Address selector is a pin: two flip-flops first
  always @(posedge clk_i) begin
    sw_meta_q <= addr_sw_i;
    sw_q <= sw_meta_q;
  end

  // Orientation and scaling of the raw count
  always @* begin
    if (dir_q)
      oriented = PHYS_TOTAL_32 - 32'h1 - raw_pos_i;
    else
      oriented = raw_pos_i;
    // custom ratio times raw, within range
    product = {32'h0, oriented} * {32'h0, spt_q};
    scaled = (product >> SPT_LOG2) % {32'h0, range_q};
    // scaling control; custom ignored when off
    if (scale_q)
      pos_d = scaled[31:0];
    else
      pos_d = oriented;
    spt_turns = {32'h0, spt_q} << TURNS_LOG2;
  end

  always @* begin
    case (all_idx_q)
      3'h0: all_attr = `ATTR_ABSOLUTE_POSITION;
      3'h1: all_attr = `ATTR_SENSOR_TYPE;
      3'h2: all_attr = `ATTR_COUNT_DIRECTION_SELECT;
      3'h3: all_attr = `ATTR_SCALING_ENABLE;
      3'h4: all_attr = `ATTR_STEPS_PER_TURN;
      3'h5: all_attr = `ATTR_TOTAL_RANGE;
      3'h6: all_attr = `ATTR_OPERATING_STATUS;
      default: all_attr = `ATTR_WARNING_REPORT;
    endcase
  end

  function [31:0] attr_val;
    input [7:0] a;
    begin
      case (a)
        `ATTR_ABSOLUTE_POSITION: attr_val = position_o;
        `ATTR_SENSOR_TYPE: attr_val = {16'h0, sensor_type};
        `ATTR_COUNT_DIRECTION_SELECT: attr_val = {31'h0, dir_q};
        `ATTR_SCALING_ENABLE: attr_val = {31'h0, scale_q};
        `ATTR_STEPS_PER_TURN: attr_val = spt_q;
        `ATTR_TOTAL_RANGE: attr_val = range_q;
        `ATTR_OPERATING_STATUS: attr_val = {24'h0, op_status_o};
        `ATTR_PHYSICAL_STEPS_PER_TURN: attr_val = PHYS_SPT;
        `ATTR_PHYSICAL_TURN_COUNT: attr_val = PHYS_TURNS;
        `ATTR_WARNING_REPORT: attr_val = {31'h0, warning_report_o};
        `ATTR_WRONG_PARAM_LIST: attr_val = {24'h0, wrong_param_o};
        default: attr_val = 32'h0;
      endcase
    end
  endfunction

  function attr_known;
    input [7:0] a;
    begin
      case (a)
        `ATTR_ABSOLUTE_POSITION, `ATTR_SENSOR_TYPE,
        `ATTR_COUNT_DIRECTION_SELECT, `ATTR_SCALING_ENABLE,
        `ATTR_STEPS_PER_TURN, `ATTR_TOTAL_RANGE,
        `ATTR_OPERATING_STATUS, `ATTR_PHYSICAL_STEPS_PER_TURN,
        `ATTR_PHYSICAL_TURN_COUNT, `ATTR_WARNING_REPORT,
        `ATTR_WRONG_PARAM_LIST: attr_known = 1'b1;
        default: attr_known = 1'b0;
      endcase
    end
  endfunction

  // Position, live direction and operating status
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      position_o <= 32'h0;
      dir_fall_q <= 1'b0;
      op_status_o <= 8'h0;
    end else begin
      position_o <= pos_d;
      if (pos_d < position_o)
        dir_fall_q <= 1'b1;
      else if (pos_d > position_o)
        dir_fall_q <= 1'b0;
      op_status_o <= 8'h0;
      op_status_o[`OPST_DIR_BIT] <= dir_fall_q;
      op_status_o[`OPST_SCALE_BIT] <= scale_q;
    end
  end

  task answer;
    input [7:0] st;
    input [7:0] a;
    input [31:0] d;
    begin
      rsp_valid_o <= 1'b1;
      rsp_last_o <= 1'b1;
      rsp_status_o <= st;
      rsp_attr_o <= a;
      rsp_data_o <= d;
    end
  endtask

  task load_factory;
    begin
      dir_q <= `COUNT_DIRECTION_RESET;
      scale_q <= `SCALING_ENABLE_RESET;
      spt_q <= PHYS_SPT;
      range_q <= PHYS_TOTAL_32;
      wrong_param_o <= 8'h0;
      warning_report_o <= 1'b0;
      warn_led_o <= 1'b0;
    end
  endtask

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q <= S_LOAD;
      dir_q <= `COUNT_DIRECTION_RESET;
      scale_q <= `SCALING_ENABLE_RESET;
      spt_q <= PHYS_SPT;
      range_q <= PHYS_TOTAL_32;
      all_idx_q <= 3'h0;
      svc_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_last_o <= 1'b0;
      rsp_status_o <= `ST_OK;
      rsp_attr_o <= 8'h0;
      rsp_data_o <= 32'h0;
      warning_report_o <= 1'b0;
      wrong_param_o <= 8'h0;
      warn_led_o <= 1'b0;
      nv_wr_o <= 1'b0;
      nv_dir_o <= 1'b0;
      nv_scale_o <= 1'b0;
      nv_spt_o <= 32'h0;
      nv_range_o <= 32'h0;
      soft_reset_o <= 1'b0;
      net_default_o <= 1'b0;
      net_addr_o <= 32'h0;
    end else begin
      rsp_valid_o <= 1'b0;
      rsp_last_o <= 1'b0;
      nv_wr_o <= 1'b0;
      soft_reset_o <= 1'b0;
      net_default_o <= 1'b0;
      svc_ready_o <= 1'b0;
      case (state_q)
        S_LOAD: begin
          // Power-up: working set taken from flash
          dir_q <= nv_dir_i;
          scale_q <= nv_scale_i;
          spt_q <= nv_spt_i;
          range_q <= nv_range_i;
          state_q <= S_IDLE;
          svc_ready_o <= 1'b1;
        end
        S_IDLE: begin
          svc_ready_o <= 1'b1;
          if (svc_valid_i) begin
            svc_ready_o <= 1'b0;
            if (svc_class_i) begin
              case (svc_code_i)
                `SVC_RESET: begin
                  if (svc_data_i[7:0] == `RESET_POWER_CYCLE) begin
                    answer(`ST_OK, 8'h0, 32'h0);
                    state_q <= S_PWR;
                  end else if (svc_data_i[7:0] == `RESET_FACTORY) begin
                    load_factory;
                    net_default_o <= 1'b1;
                    if (sw_q == 8'h0 || sw_q > `NET_SW_MAX)
                      net_addr_o <= stored_ip_i;
                    else
                      net_addr_o <= {`NET_PREFIX, sw_q};
                    answer(`ST_OK, 8'h0, 32'h0);
                    state_q <= S_SAVE;
                  end else begin
                    answer(`ST_INVALID_VALUE, 8'h0, 32'h0);
                    svc_ready_o <= 1'b1;
                  end
                end
                `SVC_GET_SINGLE: begin
                  if (svc_attr_i == `ATTR_OBJECT_REVISION)
                    answer(`ST_OK, svc_attr_i,
                      {16'h0, `OBJECT_REVISION_VAL});
                  else
                    answer(`ST_BAD_ATTR, svc_attr_i, 32'h0);
                  svc_ready_o <= 1'b1;
                end
                `SVC_RESTORE: begin
                  // reload from flash and store again
                  dir_q <= nv_dir_i;
                  scale_q <= nv_scale_i;
                  spt_q <= nv_spt_i;
                  range_q <= nv_range_i;
                  answer(`ST_OK, 8'h0, 32'h0);
                  state_q <= S_SAVE;
                end
                `SVC_SAVE: begin
                  answer(`ST_OK, 8'h0, 32'h0);
                  state_q <= S_SAVE;
                end
                default: begin
                  answer(`ST_NOT_SUPPORTED, 8'h0, 32'h0);
                  svc_ready_o <= 1'b1;
                end
              endcase
            end else begin
              case (svc_code_i)
                `SVC_GET_ALL: begin
                  all_idx_q <= 3'h0;
                  state_q <= S_ALL;
                end
                `SVC_GET_SINGLE: begin
                  if (attr_known(svc_attr_i))
                    answer(`ST_OK, svc_attr_i, attr_val(svc_attr_i));
                  else
                    answer(`ST_BAD_ATTR, svc_attr_i, 32'h0);
                  svc_ready_o <= 1'b1;
                end
                `SVC_SET_SINGLE: begin
                  svc_ready_o <= 1'b1;
                  case (svc_attr_i)
                    `ATTR_COUNT_DIRECTION_SELECT: begin
                      if (svc_data_i[31:1] == 31'h0) begin
                        dir_q <= svc_data_i[0];
                        answer(`ST_OK, svc_attr_i, 32'h0);
                      end else
                        answer(`ST_INVALID_VALUE, svc_attr_i, 32'h0);
                    end
                    `ATTR_SCALING_ENABLE: begin
                      if (svc_data_i[31:1] == 31'h0) begin
                        scale_q <= svc_data_i[0];
                        answer(`ST_OK, svc_attr_i, 32'h0);
                      end else
                        answer(`ST_INVALID_VALUE, svc_attr_i, 32'h0);
                    end
                    `ATTR_STEPS_PER_TURN: begin
                      // out of range forced to physical
                      if (svc_data_i == 32'h0 || svc_data_i > PHYS_SPT) begin
                        spt_q <= PHYS_SPT;
                        wrong_param_o[`WP_SPT_BIT] <= 1'b1;
                        warning_report_o <= 1'b1;
                        warn_led_o <= 1'b1;
                        answer(`ST_INVALID_VALUE, svc_attr_i, 32'h0);
                      end else begin
                        spt_q <= svc_data_i;
                        answer(`ST_OK, svc_attr_i, 32'h0);
                      end
                    end
                    `ATTR_TOTAL_RANGE: begin
                      if (svc_data_i == 32'h0 ||
                          svc_data_i > PHYS_TOTAL_32) begin
                        wrong_param_o[`WP_RANGE_BIT] <= 1'b1;
                        warning_report_o <= 1'b1;
                        warn_led_o <= 1'b1;
                        answer(`ST_INVALID_VALUE, svc_attr_i, 32'h0);
                      end else if (svc_data_i < spt_q) begin
                        wrong_param_o[`WP_RANGE_LT_SPT_BIT] <= 1'b1;
                        warning_report_o <= 1'b1;
                        warn_led_o <= 1'b1;
                        answer(`ST_INVALID_VALUE, svc_attr_i, 32'h0);
                      end else begin
                        range_q <= svc_data_i;
                        answer(`ST_OK, svc_attr_i, 32'h0);
                        if ({32'h0, svc_data_i} > spt_turns) begin
                          wrong_param_o[`WP_TURNS_BIT] <= 1'b1;
                          warning_report_o <= 1'b1;
                          warn_led_o <= 1'b1;
                        end
                      end
                    end
                    `ATTR_ABSOLUTE_POSITION, `ATTR_SENSOR_TYPE,
                    `ATTR_OPERATING_STATUS, `ATTR_PHYSICAL_STEPS_PER_TURN,
                    `ATTR_PHYSICAL_TURN_COUNT, `ATTR_WARNING_REPORT,
                    `ATTR_WRONG_PARAM_LIST:
                      answer(`ST_NOT_SETTABLE, svc_attr_i, 32'h0);
                    default:
                      answer(`ST_BAD_ATTR, svc_attr_i, 32'h0);
                  endcase
                end
                default: begin
                  answer(`ST_NOT_SUPPORTED, 8'h0, 32'h0);
                  svc_ready_o <= 1'b1;
                end
              endcase
            end
          end
        end
        S_ALL: begin
          // one beat per attribute for eight attributes, last flagged
          rsp_valid_o <= 1'b1;
          rsp_status_o <= `ST_OK;
          rsp_attr_o <= all_attr;
          rsp_data_o <= attr_val(all_attr);
          all_idx_q <= all_idx_q + 3'h1;
          if (all_idx_q == 3'h7) begin
            rsp_last_o <= 1'b1;
            state_q <= S_IDLE;
            svc_ready_o <= 1'b1;
          end
        end
        S_SAVE: begin
          // flash write with the current working set
          nv_wr_o <= 1'b1;
          nv_dir_o <= dir_q;
          nv_scale_o <= scale_q;
          nv_spt_o <= spt_q;
          nv_range_o <= range_q;
          if (net_default_o) begin
            state_q <= S_PWR;
          end else begin
            state_q <= S_IDLE;
            svc_ready_o <= 1'b1;
          end
        end
        S_PWR: begin
          // emulated power cycle reloads from flash
          soft_reset_o <= 1'b1;
          wrong_param_o <= 8'h0;
          warning_report_o <= 1'b0;
          warn_led_o <= 1'b0;
          state_q <= S_LOAD;
        end
        default: state_q <= S_LOAD;
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: tb/ctrl_model.sv */
`default_nettype none
module ctrl_model (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic class_o,
  output logic [7:0] code_o,
  output logic [7:0] attr_o,
  output logic [31:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {valid_o, class_o, code_o, attr_o, data_o} = '0;
  end
  // Holds the request until taken, then scrambles released lines
  task automatic issue(input logic c, input logic [7:0] cd, a,
                       input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    {valid_o, class_o, code_o, attr_o, data_o} = {1'b1, c, cd, a, d};
    // Ready read off the edge; the following edge takes the request
    while (ready_i !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    #1;
    {valid_o, class_o, code_o, attr_o, data_o} = {1'b0, ~c, ~cd, ~a, ~d};
  endtask
endmodule
`default_nettype wire

/* File: tb/position_sensor_object_scaling_tb_top.sv */
`default_nettype none
module position_sensor_object_scaling_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_b_i, svc_valid_i, svc_class_i, nv_dir_i, nv_scale_i;
  logic [7:0] svc_code_i, svc_attr_i, addr_sw_i;
  logic [31:0] svc_data_i, raw_pos_i, nv_spt_i, nv_range_i, stored_ip_i;
  logic svc_ready_o, rsp_valid_o, rsp_last_o, warning_report_o, warn_led_o;
  logic nv_wr_o, nv_dir_o, nv_scale_o, soft_reset_o, net_default_o;
  logic [7:0] rsp_status_o, rsp_attr_o, op_status_o, wrong_param_o;
  logic [31:0] rsp_data_o, position_o, nv_spt_o, nv_range_o, net_addr_o;
  logic [49:0] exp_q[$];
  logic [49:0] e;
  logic [31:0] r;
  logic [31:0] ga[8];
  logic [7:0] ga_at[8] = '{8'h03, 8'h0b, 8'h0c, 8'h0e, 8'h10, 8'h11,
                           8'h29, 8'h2f};
  logic [31:0] bad[2] = '{32'h0, 32'h11};
  logic [7:0] sw[2] = '{8'h05, 8'h00};
  int num_errors = 0;
  int check_count = 0;
  // Arbitrary stored address
  localparam logic [31:0] IP_STORED = 32'h0a0b0c0d;
  wire [2:0] pulses = {net_default_o, soft_reset_o, nv_wr_o};

  position_sensor_object_scaling #(.SPT_LOG2(4), .TURNS_LOG2(2)) DUT (.*);
  ctrl_model CTRL (.clk_i(clk_i), .ready_i(svc_ready_o),
    .valid_o(svc_valid_i), .class_o(svc_class_i), .code_o(svc_code_i),
    .attr_o(svc_attr_i), .data_o(svc_data_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic close_out;
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [79:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Full of 0 leaves attribute and data unchecked
  task automatic note(input logic lst, input logic [7:0] st, at,
                      input logic [31:0] d, input logic full);
    exp_q.push_back({full, lst, st, at, d});
  endtask

  task automatic req(input logic c, input logic [7:0] cd, a,
                     input logic [31:0] d, input logic [7:0] st);
    note(1'b1, st, 8'h00, 32'h0, 1'b0);
    CTRL.issue(c, cd, a, d);
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic rd(input logic c, input logic [7:0] cd, a,
                    input logic [31:0] xd);
    note(1'b1, 8'h00, a, xd, 1'b1);
    CTRL.issue(c, cd, a, 32'h0);
  endtask

  task automatic wait_pulse(input int w);
    for (int n = 0; n < 20; n++) begin
      if (pulses[w] === 1'b1) return;
      @(posedge clk_i);
      #1;
    end
    chk(pulses[w], 1'b1);
  endtask

  task automatic pos_chk(input logic [31:0] raw, exp);
    @(posedge clk_i);
    #1;
    raw_pos_i = raw;
    repeat (2) @(posedge clk_i);
    #1;
    chk(position_o, exp);
  endtask

  always @(posedge clk_i) begin
    if (rsp_valid_o === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      chk({rsp_last_o, rsp_status_o,
           e[49] ? {rsp_attr_o, rsp_data_o} : e[39:0]}, e[48:0]);
    end
  end

  initial begin
    #100000;
    num_errors++;
    close_out();
  end

  initial begin
    r = $urandom(32'hcb21);
    {nv_dir_i, nv_scale_i, nv_spt_i, nv_range_i} = {2'b01, 32'h10, 32'h40};
    stored_ip_i = IP_STORED;
    {rst_b_i, raw_pos_i, addr_sw_i} = '0;
    repeat (6) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rd(1'b1, 8'h0e, 8'h01, 32'h2);
    req(1'b0, 8'h10, 8'h03, $urandom, 8'h0e);
    req(1'b0, 8'h10, 8'h0b, $urandom, 8'h0e);
    req(1'b0, 8'h10, 8'h55, 32'h0, 8'h14);
    req(1'b0, 8'h4b, 8'h03, 32'h0, 8'h08);
    r = $urandom % 64;
    pos_chk(r, r);
    ga = '{r, 32'h2, 32'h0, 32'h1, 32'h10, 32'h40, 32'h2, 32'h0};
    foreach (ga_at[i]) note(i == 7, 8'h00, ga_at[i], ga[i], 1'b1);
    CTRL.issue(1'b0, 8'h01, 8'h00, 32'h0);
    req(1'b0, 8'h10, 8'h10, 32'd8, 8'h00);
    req(1'b0, 8'h10, 8'h11, 32'd32, 8'h00);
    note(1'b1, 8'h00, 8'h00, 32'h0, 1'b0);
    CTRL.issue(1'b1, 8'h16, 8'h00, 32'h0);
    wait_pulse(0);
    chk({nv_dir_o, nv_scale_o, nv_spt_o, nv_range_o},
        {2'b01, 32'd8, 32'd32});
    repeat (4) begin
      r = $urandom % 64;
      pos_chk(r, (r * 8 >> 4) % 32);
    end
    req(1'b0, 8'h10, 8'h0e, 32'h0, 8'h00);
    pos_chk(40, 40);
    chk(op_status_o[1], 1'b0);
    req(1'b0, 8'h10, 8'h0c, 32'h1, 8'h00);
    pos_chk(10, 53);
    pos_chk(11, 52);
    chk(op_status_o[0], 1'b1);
    req(1'b0, 8'h10, 8'h0c, 32'h0, 8'h00);
    pos_chk(12, 12);
    pos_chk(13, 13);
    chk(op_status_o[0], 1'b0);
    req(1'b0, 8'h10, 8'h0e, 32'h1, 8'h00);
    foreach (bad[i]) req(1'b0, 8'h10, 8'h10, bad[i], 8'h09);
    chk({wrong_param_o[0], warning_report_o, warn_led_o}, 3'b111);
    pos_chk(40, 8);
    chk(op_status_o[1], 1'b1);
    req(1'b0, 8'h10, 8'h11, 32'd8, 8'h09);
    chk(wrong_param_o[2], 1'b1);
    req(1'b0, 8'h10, 8'h11, 32'd65, 8'h09);
    chk(wrong_param_o[1], 1'b1);
    req(1'b0, 8'h10, 8'h10, 32'd8, 8'h00);
    req(1'b0, 8'h10, 8'h11, 32'd64, 8'h00);
    chk(wrong_param_o[3], 1'b1);
    pos_chk(40, 20);
    req(1'b1, 8'h05, 8'h00, 32'h2, 8'h09);
    foreach (sw[i]) begin
      addr_sw_i = sw[i];
      repeat (4) @(posedge clk_i);
      #1;
      note(1'b1, 8'h00, 8'h00, 32'h0, 1'b0);
      CTRL.issue(1'b1, 8'h05, 8'h00, 32'h1);
      wait_pulse(2);
      chk(net_addr_o, sw[i] ? {24'hc0a801, sw[i]} : IP_STORED);
      wait_pulse(0);
      chk({nv_dir_o, nv_scale_o, nv_spt_o, nv_range_o},
          {2'b01, 32'd16, 32'd64});
      wait_pulse(1);
      repeat (3) @(posedge clk_i);
      #1;
      chk({wrong_param_o, warning_report_o, warn_led_o}, 10'h0);
    end
    req(1'b0, 8'h10, 8'h10, 32'd8, 8'h00);
    note(1'b1, 8'h00, 8'h00, 32'h0, 1'b0);
    CTRL.issue(1'b1, 8'h05, 8'h00, 32'h0);
    wait_pulse(1);
    rd(1'b0, 8'h0e, 8'h10, 32'd16);
    req(1'b0, 8'h10, 8'h10, 32'd8, 8'h00);
    note(1'b1, 8'h00, 8'h00, 32'h0, 1'b0);
    CTRL.issue(1'b1, 8'h15, 8'h00, 32'h0);
    wait_pulse(0);
    chk({nv_dir_o, nv_scale_o, nv_spt_o, nv_range_o},
        {2'b01, 32'd16, 32'd64});
    repeat (4) @(posedge clk_i);
    chk(exp_q.size(), 0);
    close_out();
  end
endmodule
`default_nettype wire

/* File: tb/pss_props.sv */
`default_nettype none
module pss_props (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic svc_valid_i,
  input wire logic svc_ready_o,
  input wire logic svc_class_i,
  input wire logic [7:0] svc_code_i,
  input wire logic [7:0] svc_attr_i,
  input wire logic [31:0] svc_data_i,
  input wire logic [7:0] addr_sw_i,
  input wire logic rsp_valid_o,
  input wire logic rsp_last_o,
  input wire logic [7:0] rsp_status_o,
  input wire logic [7:0] rsp_attr_o,
  input wire logic [31:0] rsp_data_o,
  input wire logic [7:0] wrong_param_o,
  input wire logic warning_report_o,
  input wire logic warn_led_o,
  input wire logic nv_wr_o,
  input wire logic soft_reset_o,
  input wire logic net_default_o,
  input wire logic [31:0] net_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire take = svc_valid_i && svc_ready_o;

  chk_busy_after_take:
    assert property (take && (svc_class_i ? (svc_code_i == 8'h15 ||
      svc_code_i == 8'h16) : svc_code_i == 8'h01) |=> !svc_ready_o)
    else $error("ready stayed high after a request");
  chk_set_answer:
    assert property (take && !svc_class_i && svc_code_i == 8'h10
      |=> rsp_valid_o && rsp_last_o) else $error("set got no answer");
  chk_getall_beats:
    assert property (take && !svc_class_i && svc_code_i == 8'h01 |-> ##2
      (rsp_valid_o && !rsp_last_o)[*7] ##1
      (rsp_valid_o && rsp_last_o && rsp_attr_o == 8'h2f))
    else $error("get-all beats wrong");
  chk_revision_read:
    assert property (take && svc_class_i && svc_code_i == 8'h0e &&
      svc_attr_i == 8'h01 |=> rsp_status_o == 8'h00 &&
      rsp_data_o == 32'h0002) else $error("revision read wrong");
  chk_ro_refused:
    assert property (take && !svc_class_i && svc_code_i == 8'h10 &&
      (svc_attr_i == 8'h03 || svc_attr_i == 8'h0b)
      |=> rsp_status_o == 8'h0e) else $error("read-only write taken");
  chk_save_pulse:
    assert property (take && svc_class_i && svc_code_i == 8'h16
      |-> ##2 nv_wr_o) else $error("save wrote no flash");
  chk_factory_seq:
    assert property (take && svc_class_i && svc_code_i == 8'h05 &&
      svc_data_i[7:0] == 8'h01 |=> net_default_o ##2 soft_reset_o)
    else $error("factory reset sequence wrong");
  chk_power_cycle:
    assert property (take && svc_class_i && svc_code_i == 8'h05 &&
      svc_data_i[7:0] == 8'h00 |=> !net_default_o ##1 soft_reset_o)
    else $error("power cycle reset wrong");
  chk_switch_addr:
    assert property (net_default_o && addr_sw_i != 8'h00 &&
      addr_sw_i != 8'hff && $past(addr_sw_i, 3) == addr_sw_i
      |-> net_addr_o == {24'hc0a801, addr_sw_i})
    else $error("switch address wrong");
  chk_warn_flags:
    assert property ($rose(wrong_param_o[0]) |-> ##[0:1]
      (warning_report_o && warn_led_o)) else $error("warning not shown");
endmodule

bind position_sensor_object_scaling pss_props u_props (.*);
`default_nettype wire
